// >>> sfpw_pkg.sv
package sfpw_pkg;

  // Opcodes seen by the power logic
  localparam logic [7:0] OPC_SLEEP = 8'hb9;
  localparam logic [7:0] OPC_WAKE = 8'hab;

  // Bit counter of the serial shifter
  localparam int BIT_CNT_W = 3;
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;
  localparam logic [2:0] BIT_CNT_FIRST = 3'h1;
  localparam logic [2:0] BIT_CNT_MSB = 3'h7;

  // Reset values of bytes and flags
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;

  // Core clock period and longest wake time
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int WAKE_DELAY_MAX_NS = 8000;

  // A longest time rounds down, never below one cycle
  localparam int WAKE_DELAY_RAW = WAKE_DELAY_MAX_NS / CLOCK_PERIOD_NS;
  localparam int WAKE_DELAY_CYCLES = (WAKE_DELAY_RAW < 1) ? 1 : WAKE_DELAY_RAW;
  localparam int WAKE_CNT_W = 9;
  localparam logic [8:0] WAKE_CNT_LOAD = 9'(WAKE_DELAY_CYCLES - 1);
  localparam logic [8:0] WAKE_CNT_ZERO = 9'h000;

  // Power states
  typedef enum logic [1:0] {
    PWR_STANDBY,
    PWR_SLEEP,
    PWR_WAKING
  } sfpw_power_type;

endpackage

// >>> sfpw_sync.sv
`timescale 1ns/1ps

// Two-flop level synchroniser, one per bit
module sfpw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1; // Read only by the second stage
  logic [WIDTH-1:0] stage2;

  // Plain double register, no logic between stages
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
    end
  end

  assign syncOut = stage2;

endmodule

// >>> sfpw_link.sv
`timescale 1ns/1ps

// Logic on the serial clock: shifter, pause, output launch
module sfpw_link (
  // Serial pins
  input wire logic sck,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic holdN,
  input wire logic si,
  output logic so,
  output logic soEn,
  // Towards the core (quasi-static or toggle events)
  input wire logic [7:0] txByte,
  input wire logic driveEnable,
  output logic [2:0] bitCnt,
  output logic [7:0] rxData,
  output logic rxToggle,
  output logic paused
);

  logic frameRst; // Frame reset while chip select is high
  logic frameOpen; // Set by the first rising edge of a frame
  logic holdAtFall; // Hold pin seen at the last falling edge
  logic [7:0] shiftIn; // Incoming bits, first bit ends up MSB
  logic [2:0] next_bitCnt;
  logic [7:0] next_shiftIn;
  logic [7:0] next_rxData;
  logic next_rxToggle;
  logic soBit; // Launched bit
  logic next_soBit;

  assign frameRst = csN | ~rst_n;

  // Pause: immediate while clock is low, held from the falling edge while high
  assign paused = ~csN & (sck ? holdAtFall : ~holdN);

  // Frame flag, cleared the moment chip select goes high
  always_ff @(posedge sck or posedge frameRst) begin
    if (frameRst) begin
      frameOpen <= sfpw_pkg::FLAG_RESET;
    end else if (holdN) begin
      frameOpen <= 1'b1;
    end
  end

  // Next values of the input shifter
  always_comb begin
    next_bitCnt = bitCnt;
    next_shiftIn = shiftIn;
    next_rxData = rxData;
    next_rxToggle = rxToggle;
    // Pause level of the low phase that this rising edge ends
    if (!csN && holdN) begin // Clock ignored while paused
      // Count restarts on the first edge of every frame
      next_bitCnt = frameOpen ? 3'(bitCnt + 3'h1) : sfpw_pkg::BIT_CNT_FIRST;
      next_shiftIn = {shiftIn[6:0], si}; // Sampled on rising edge
      if (next_bitCnt == sfpw_pkg::BIT_CNT_RESET) begin
        next_rxData = {shiftIn[6:0], si};
        next_rxToggle = ~rxToggle; // One toggle per whole byte
      end
    end
  end

  // Rising-edge registers
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt <= sfpw_pkg::BIT_CNT_RESET;
      shiftIn <= sfpw_pkg::BYTE_RESET;
      rxData <= sfpw_pkg::BYTE_RESET;
      rxToggle <= sfpw_pkg::FLAG_RESET;
    end else begin
      bitCnt <= next_bitCnt;
      shiftIn <= next_shiftIn;
      rxData <= next_rxData;
      rxToggle <= next_rxToggle;
    end
  end

  // Next launched bit: MSB first, frozen while paused
  always_comb begin
    next_soBit = soBit;
    if (!csN && holdN) begin
      next_soBit = txByte[3'(sfpw_pkg::BIT_CNT_MSB - bitCnt)];
    end
  end

  // Falling-edge registers: launch and hold capture
  always_ff @(negedge sck or negedge rst_n) begin
    if (!rst_n) begin
      soBit <= sfpw_pkg::FLAG_RESET;
      holdAtFall <= sfpw_pkg::FLAG_RESET;
    end else begin
      soBit <= next_soBit;
      holdAtFall <= ~csN & ~holdN;
    end
  end

  // Output floats while paused or deselected
  assign so = soBit;
  assign soEn = ~csN & ~paused & driveEnable;

endmodule

// >>> sfpw_ctrl.sv
`timescale 1ns/1ps

module sfpw_ctrl (
  // Core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial link pins
  input wire logic sck,
  input wire logic csN,
  input wire logic holdN,
  input wire logic wpN,
  input wire logic si,
  output logic so,
  output logic soEn,
  // Array side
  input wire logic busy,
  input wire logic setWriteEnable,
  input wire logic [7:0] txByte,
  input wire logic txEnable,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic abortPulse,
  // Status
  output logic writeEnableLatch,
  output logic standby,
  output logic deepSleep,
  output logic waking,
  output logic pausedStatus,
  output logic writeProtect
);

  // Synchronised pins and link signals
  logic csNSync; // Chip select, core domain
  logic holdNSync; // Pause pin, core domain
  logic wpNSync; // Write protect, core domain
  logic pausedSync; // Link pause state, core domain
  logic rxToggleSync; // Byte event toggle, core domain
  logic csNLast; // Previous chip select level
  logic rxToggleLast; // Previous toggle level

  // Link outputs
  logic [2:0] linkBitCnt; // Stable once select is high
  logic [7:0] linkRxData; // Held a whole byte time
  logic linkRxToggle;
  logic linkPaused;

  // Power and command state
  sfpw_pkg::sfpw_power_type power; // Current power state
  sfpw_pkg::sfpw_power_type next_power;
  logic [8:0] wakeCnt; // Cycles left before standby
  logic [8:0] next_wakeCnt;

  // Frame tracking
  logic [7:0] opcode; // First byte of the current frame
  logic [7:0] next_opcode;
  logic opcodeSeen; // A whole first byte has arrived
  logic next_opcodeSeen;

  // Received byte towards the array
  logic [7:0] next_rxByte;
  logic next_rxValid;

  // Latch and abort
  logic next_writeEnableLatch;
  logic next_abortPulse;

  // Single-cycle events and the output enable in the core domain
  logic frameStart; // Chip select fell
  logic frameEnd; // Chip select rose
  logic byteEvent; // Link finished a whole byte
  logic alignedEnd; // Release after whole bytes only
  logic abortGo; // Release while the pause pin is low
  logic sleepGo; // Valid sleep frame ended
  logic wakeGo; // Valid wake frame ended
  logic linkDrive; // Output allowed by the core

  // Chip select into the core domain; idles high so no false edge after reset
  sfpw_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'h1)
  ) u_syncCsN (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(csN),
    .syncOut(csNSync)
  );

  // Pause pin into the core domain; idles high
  sfpw_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'h1)
  ) u_syncHoldN (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(holdN),
    .syncOut(holdNSync)
  );

  // Write protect pin, still followed while paused
  sfpw_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'h1)
  ) u_syncWpN (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(wpN),
    .syncOut(wpNSync)
  );

  // Pause state of the link, for status only
  sfpw_sync #(
    .WIDTH(1),
    .RESET_VALUE(sfpw_pkg::FLAG_RESET)
  ) u_syncPaused (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(linkPaused),
    .syncOut(pausedSync)
  );

  // Byte toggle; one level change per byte, so a plain
  // double register is enough and no event is lost
  sfpw_sync #(
    .WIDTH(1),
    .RESET_VALUE(sfpw_pkg::FLAG_RESET)
  ) u_syncToggle (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(linkRxToggle),
    .syncOut(rxToggleSync)
  );

  // Serial-clock logic: shifter, pause and output launch
  sfpw_link u_link (
    .sck(sck),
    .rst_n(rst_n),
    .csN(csN),
    .holdN(holdN),
    .si(si),
    .so(so),
    .soEn(soEn),
    .txByte(txByte),
    .driveEnable(linkDrive),
    .bitCnt(linkBitCnt),
    .rxData(linkRxData),
    .rxToggle(linkRxToggle),
    .paused(linkPaused)
  );

  // Previous levels for edge detection; reset to the idle levels
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      csNLast <= 1'h1;
      rxToggleLast <= sfpw_pkg::FLAG_RESET;
    end else begin
      csNLast <= csNSync;
      rxToggleLast <= rxToggleSync;
    end
  end

  // Frame edges and byte events
  assign frameStart = csNLast & ~csNSync;
  assign frameEnd = ~csNLast & csNSync;
  assign byteEvent = rxToggleSync ^ rxToggleLast;

  // Bit count is read only after select rose: the serial clock has
  // stopped by then and the count has been still for a whole half cycle
  // plus two core cycles, so it needs no handshake of its own
  assign alignedEnd = frameEnd & opcodeSeen &
    (linkBitCnt == sfpw_pkg::BIT_CNT_RESET);

  // Release while the pause pin is still low aborts the frame
  assign abortGo = frameEnd & ~holdNSync;

  // Sleep only from standby and never over running self-timed work;
  // pause does not touch the busy flag, so such work runs on
  assign sleepGo = alignedEnd & ~abortGo & ~busy &
    (opcode == sfpw_pkg::OPC_SLEEP) & (power == sfpw_pkg::PWR_STANDBY);

  // Only the wake opcode leaves deep sleep
  assign wakeGo = alignedEnd & ~abortGo &
    (opcode == sfpw_pkg::OPC_WAKE) & (power == sfpw_pkg::PWR_SLEEP);

  // Next values of the frame tracker
  always_comb begin
    next_opcode = opcode;
    next_opcodeSeen = opcodeSeen;
    if (frameStart) begin
      // New frame: forget the old opcode
      next_opcodeSeen = sfpw_pkg::FLAG_RESET;
    end else if (byteEvent && !opcodeSeen) begin
      // Only the first byte counts; later bytes are ignored
      next_opcode = linkRxData;
      next_opcodeSeen = 1'h1;
    end
  end

  // Frame tracker registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      opcode <= sfpw_pkg::BYTE_RESET;
      opcodeSeen <= sfpw_pkg::FLAG_RESET;
    end else begin
      opcode <= next_opcode;
      opcodeSeen <= next_opcodeSeen;
    end
  end

  // Next power state and wake countdown
  always_comb begin
    next_power = power;
    next_wakeCnt = wakeCnt;
    unique case (power)
      sfpw_pkg::PWR_STANDBY: begin
        if (sleepGo) begin
          next_power = sfpw_pkg::PWR_SLEEP;
        end
      end
      sfpw_pkg::PWR_SLEEP: begin
        // Anything but a clean wake frame leaves us asleep
        if (wakeGo) begin
          next_power = sfpw_pkg::PWR_WAKING;
          next_wakeCnt = sfpw_pkg::WAKE_CNT_LOAD;
        end
      end
      sfpw_pkg::PWR_WAKING: begin
        // Standby within the longest wake time
        if (wakeCnt == sfpw_pkg::WAKE_CNT_ZERO) begin
          next_power = sfpw_pkg::PWR_STANDBY;
        end else begin
          next_wakeCnt = wakeCnt - 9'h001;
        end
      end
      default: begin
        // Unused code: fall back to standby
        next_power = sfpw_pkg::PWR_STANDBY;
      end
    endcase
  end

  // Power registers; power-up lands in standby
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power <= sfpw_pkg::PWR_STANDBY;
      wakeCnt <= sfpw_pkg::WAKE_CNT_ZERO;
    end else begin
      power <= next_power;
      wakeCnt <= next_wakeCnt;
    end
  end

  // Next received byte; nothing reaches the array unless in standby
  always_comb begin
    next_rxByte = rxByte;
    next_rxValid = sfpw_pkg::FLAG_RESET;
    if (byteEvent && power == sfpw_pkg::PWR_STANDBY) begin
      next_rxByte = linkRxData;
      next_rxValid = 1'h1;
    end
  end

  // Received byte registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxByte <= sfpw_pkg::BYTE_RESET;
      rxValid <= sfpw_pkg::FLAG_RESET;
    end else begin
      rxByte <= next_rxByte;
      rxValid <= next_rxValid;
    end
  end

  // Next latch value; a set in the abort cycle wins
  always_comb begin
    next_writeEnableLatch = writeEnableLatch;
    next_abortPulse = abortGo;
    if (abortGo) begin
      next_writeEnableLatch = sfpw_pkg::FLAG_RESET;
    end
    if (setWriteEnable && power == sfpw_pkg::PWR_STANDBY) begin
      // Deep sleep ignores the set as well
      next_writeEnableLatch = 1'h1;
    end
  end

  // Latch and abort registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      writeEnableLatch <= sfpw_pkg::FLAG_RESET;
      abortPulse <= sfpw_pkg::FLAG_RESET;
    end else begin
      writeEnableLatch <= next_writeEnableLatch;
      abortPulse <= next_abortPulse;
    end
  end

  // Status decode of the power register
  assign standby = (power == sfpw_pkg::PWR_STANDBY);
  assign deepSleep = (power == sfpw_pkg::PWR_SLEEP);
  assign waking = (power == sfpw_pkg::PWR_WAKING);

  // Pause and protect status
  assign pausedStatus = pausedSync;
  assign writeProtect = ~wpNSync;

  // Output only in standby with txEnable set; may change within a frame
  assign linkDrive = txEnable & standby;

endmodule

// >>> sfpw_ctrl_props.sv
`timescale 1ns/1ps
// Checker on the control ports
module sfpw_ctrl_props (
  input logic clock,
  input logic rst_n,
  input logic csN,
  input logic holdN,
  input logic soEn,
  input logic writeEnableLatch,
  input logic standby,
  input logic deepSleep,
  input logic waking,
  input logic pausedStatus
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Select dropped while paused
  sequence s_drop; csN && !holdN && pausedStatus; endsequence
  property p_one; !(standby && deepSleep); endproperty
  a_one: assert property (p_one) else $error("both");
  property p_up; $rose(rst_n) |-> standby; endproperty
  a_up: assert property (p_up) else $error("up");
  property p_wake; waking |-> ##[1:340] standby; endproperty
  a_wake: assert property (p_wake) else $error("slow");
  property p_go; $rose(waking) |-> csN; endproperty
  a_go: assert property (p_go) else $error("go");
  property p_stay; $fell(deepSleep) |-> waking; endproperty
  a_stay: assert property (p_stay) else $error("stay");
  property p_drop; s_drop |-> ##[1:6] !writeEnableLatch; endproperty
  a_drop: assert property (p_drop) else $error("drop");
  property p_end; csN [*6] |-> !pausedStatus; endproperty
  a_end: assert property (p_end) else $error("held");
  property p_off; csN [*6] |-> !soEn; endproperty
  a_off: assert property (p_off) else $error("driven");
endmodule
bind sfpw_ctrl sfpw_ctrl_props u_props (.*);

// >>> sfpw_host.sv
`timescale 1ns/1ps
// Host: clock idles low outside frames
module sfpw_host (
  output logic sck = 1'b0,
  output logic csN = 1'b1,
  output logic holdN = 1'b1,
  output logic si = 1'b0,
  input logic so
);
  logic [7:0] fullCap = 8'h00; // Full-cycle capture
  logic [7:0] halfCap = 8'h00; // Half-cycle capture
  // Top bit first, each bit held over a whole rise
  task automatic sel(input logic [15:0] b, input int n);
    csN = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      si = b[i];
      #62.5 sck = 1'b1;
      halfCap = {halfCap[6:0], so};
      #62.5 fullCap = {fullCap[6:0], so};
      sck = 1'b0;
    end
  endtask
  // Released data line shows the inverse
  task automatic frame(input logic [15:0] b, input int n);
    sel(b, n);
    #62.5 csN = 1'b1;
    si = ~si;
  endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0, rst_n = 1'b0, setWriteEnable = 1'b0, busy = 1'b0, txEnable = 1'b0;
  logic wpN = 1'b1, so, soEn, rxValid, abortPulse, waking, writeProtect;
  logic writeEnableLatch, standby, deepSleep, pausedStatus;
  logic [7:0] b, rxByte, txByte = 8'h00, expQ[$];
  wire sck, csN, holdN, si;
  int mismatches = 0, numChecks = 0;
  integer seed = 32'h641b9da9;
  initial forever #12.5 clock = ~clock;
  sfpw_host u_host (.*);
  sfpw_ctrl u_dut (.*);
  task automatic check(input string n, input logic [7:0] s, e);
    numChecks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    if (mismatches == 0 && numChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Each received byte against the oldest note
  always @(negedge clock) if (rxValid === 1'b1) begin
    if (expQ.size() > 0) check("rxByte", rxByte, expQ.pop_front());
    else check("rxValid", 8'h01, 8'h00);
  end
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) begin
      b = 8'($random(seed)) & 8'h7f;
      expQ.push_back(b);
      u_host.frame({b, 8'h00}, 8);
      cyc(8);
    end
    expQ.push_back(8'hb9);
    u_host.frame(16'hb900, 8);
    cyc(8);
    check("sleep", deepSleep, 8'h01);
    for (int i = 7; i < 12; i += 4) begin
      u_host.frame(16'hab3c, i);
      cyc(8);
      check("sleep", deepSleep, 8'h01);
    end
    u_host.frame(16'hab3c, 16);
    for (int i = 0; i < 400 && standby !== 1'b1; i++) cyc(1);
    check("standby", standby, 8'h01);
    @(posedge clock) setWriteEnable <= 1'b1;
    @(posedge clock) setWriteEnable <= 1'b0;
    u_host.sel(16'h0600, 4);
    #20 u_host.holdN = 1'b0;
    cyc(8);
    check("paused", pausedStatus, 8'h01);
    check("latch", writeEnableLatch, 8'h01);
    u_host.csN = 1'b1;
    cyc(8);
    check("latch", writeEnableLatch, 8'h00);
    check("queue", 8'(expQ.size()), 8'h00);
    test_done();
  end
endmodule
